// file: hdl/clock_ctrl_pkg.sv
/*
 * Shared constants and types for the CPU clock source and core voltage control
 * block: register address and field layout, reset value, bus encodings and the
 * states of the clock source switch.
 * Assumes a 32-bit AHB-Lite register bus and oscillator levels that are
 * synchronous to clk_sys.
 */
package clock_ctrl_pkg;

    // ----------------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------------
    localparam logic [31:0] CTRL_ADDR  = 32'h0000ff00;
    localparam int          CTRL_W     = 4;
    localparam int          SEL_BIT    = 3;
    localparam int          OSC_BIT    = 2;
    localparam int          RSV_BIT    = 1;
    localparam int          VDC_BIT    = 0;
    localparam logic [3:0]  CTRL_RESET = 4'h0;

    // ----------------------------------------------------------------------
    // bus encodings
    // ----------------------------------------------------------------------
    localparam int          HTRANS_ACTIVE_BIT = 1;
    localparam logic        HRESP_OKAY        = 1'b0;
    localparam logic [31:0] RDATA_NONE        = 32'h00000000;

    // ----------------------------------------------------------------------
    // oscillator and supply figures
    // ----------------------------------------------------------------------
    localparam int SLOW_XTAL_HZ = 32768;
    localparam int SLOW_RC_HZ   = 60000;
    localparam int VDD_LOW_MV   = 1300;
    localparam int VDD_HIGH_MV  = 2200;

    typedef logic [CTRL_W-1:0] ctrl_t;

    typedef enum logic [1:0] {
        SRC_SLOW,
        SRC_TO_FAST,
        SRC_FAST,
        SRC_TO_SLOW
    } src_state_t;

endpackage

// file: hdl/clock_source_switch.sv
/*
 * Glitch-free selection between the slow and the fast oscillator.
 * Assumes both oscillator levels are synchronous to clk_sys, which runs far
 * faster than either oscillator.
 */
`timescale 1ns/1ps
module clock_source_switch
    import clock_ctrl_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic slow_osc,
    input  wire logic fast_osc,
    input  wire logic want_fast,
    output logic      cpu_clock,
    output logic      on_fast
);
    import clock_ctrl_pkg::*;

    src_state_t state;
    src_state_t next_state;
    logic       next_cpu_clock;

    // ----------------------------------------------------------------------
    // leave a source only while it is low, join the next only while it is low
    // ----------------------------------------------------------------------
    always_comb begin
        next_state     = state;
        next_cpu_clock = 1'b0;
        case (state)
            SRC_SLOW: begin
                next_cpu_clock = slow_osc;
                if (want_fast && !slow_osc) begin
                    next_state     = SRC_TO_FAST;
                    next_cpu_clock = 1'b0;
                end
            end
            SRC_TO_FAST: begin
                if (!want_fast) begin
                    next_state = SRC_TO_SLOW;
                end else if (!fast_osc) begin
                    next_state = SRC_FAST;
                end
            end
            SRC_FAST: begin
                next_cpu_clock = fast_osc;
                if (!want_fast && !fast_osc) begin
                    next_state     = SRC_TO_SLOW;
                    next_cpu_clock = 1'b0;
                end
            end
            SRC_TO_SLOW: begin
                if (!slow_osc) begin
                    next_state = SRC_SLOW;
                end
            end
            default: begin
                next_state = SRC_SLOW;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state     <= SRC_SLOW;
            cpu_clock <= 1'b0;
        end else begin
            state     <= next_state;
            cpu_clock <= next_cpu_clock;
        end
    end

    assign on_fast = (state == SRC_FAST);

    // ----------------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------------
    property p_no_runt;
        @(posedge clk_sys) disable iff (rst)
        $fell(cpu_clock) |-> $past(state == SRC_FAST ? !fast_osc : !slow_osc);
    endproperty
    a_no_runt: assert property (p_no_runt) else $error("clock high phase cut short");

endmodule

// file: hdl/cpu_clock_and_core_voltage_ctrl.sv
/*
 * CPU clock source and core voltage control: one 4-bit control register on
 * AHB-Lite selecting the CPU clock source, starting the fast oscillator and
 * choosing the core supply level, plus the glitch-free source switch.
 * Assumes a single AHB-Lite master, oscillator levels synchronous to clk_sys,
 * and analog oscillators and regulator outside the block.
 */
// How it works
// - bit 3 picks the CPU clock source, 1 fast, 0 slow; reads back.
// - bit 2 starts or stops the fast oscillator; reads back.
// - bit 0 requests high core supply when 1, low when 0; reads back.
// - with RC slow oscillator the supply stays high whatever bit 0 holds.
// - reset clears all three bits: slow clock, fast oscillator off, low supply except with RC slow oscillator.
// - bit 1 is unused, reads zero, writes ignored.
// - with low supply and fast oscillator off, selecting fast clock is refused.
// - slow oscillator, 32.768 kHz crystal or 60 kHz RC, is the default clock.
`timescale 1ns/1ps
module cpu_clock_and_core_voltage_ctrl #(
    parameter logic slow_osc_is_rc = 1'b0
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        slow_osc,
    input  wire logic        fast_osc,
    output logic             cpu_clock,
    output logic             cpu_on_fast,
    output logic             fast_osc_run,
    output logic             core_supply_level
);
    import clock_ctrl_pkg::*;

    // ----------------------------------------------------------------------
    // bus address phase
    // ----------------------------------------------------------------------
    logic addr_take;
    logic addr_hit;
    logic wr_pend;
    logic next_wr_pend;
    logic rd_pend;
    logic next_rd_pend;

    assign addr_take = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;
    assign addr_hit  = (haddr == CTRL_ADDR);

    always_comb begin
        next_wr_pend = addr_take && hwrite && addr_hit;
        next_rd_pend = addr_take && !hwrite;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
        end else begin
            wr_pend <= next_wr_pend;
            rd_pend <= next_rd_pend;
        end
    end

    // zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;

    // ----------------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------------
    logic  cpu_clock_select;
    logic  fast_osc_enable;
    logic  core_voltage_select;
    logic  next_cpu_clock_select;
    logic  next_fast_osc_enable;
    logic  next_core_voltage_select;
    logic  next_core_supply_level;
    logic  supply_high;
    logic  sel_refused;
    ctrl_t ctrl_view;

    // effective supply: RC slow oscillator pins it high
    assign supply_high = slow_osc_is_rc || core_voltage_select;
    assign sel_refused = !supply_high && !fast_osc_enable;

    always_comb begin
        next_cpu_clock_select    = cpu_clock_select;
        next_fast_osc_enable     = fast_osc_enable;
        next_core_voltage_select = core_voltage_select;
        if (wr_pend) begin
            next_cpu_clock_select    = hwdata[SEL_BIT] && !sel_refused;
            next_fast_osc_enable     = hwdata[OSC_BIT];
            next_core_voltage_select = hwdata[VDC_BIT];
        end
        next_core_supply_level = slow_osc_is_rc || next_core_voltage_select;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cpu_clock_select    <= CTRL_RESET[SEL_BIT];
            fast_osc_enable     <= CTRL_RESET[OSC_BIT];
            core_voltage_select <= CTRL_RESET[VDC_BIT];
            core_supply_level   <= slow_osc_is_rc || CTRL_RESET[VDC_BIT];
        end else begin
            cpu_clock_select    <= next_cpu_clock_select;
            fast_osc_enable     <= next_fast_osc_enable;
            core_voltage_select <= next_core_voltage_select;
            core_supply_level   <= next_core_supply_level;
        end
    end

    assign fast_osc_run = fast_osc_enable;

    // ----------------------------------------------------------------------
    // read data, forwarded from a write in the same cycle
    // ----------------------------------------------------------------------
    logic [31:0] next_hrdata;

    always_comb begin
        ctrl_view          = CTRL_RESET;
        ctrl_view[SEL_BIT] = next_cpu_clock_select;
        ctrl_view[OSC_BIT] = next_fast_osc_enable;
        ctrl_view[RSV_BIT] = 1'b0;
        ctrl_view[VDC_BIT] = next_core_voltage_select;
        next_hrdata        = hrdata;
        if (addr_take && !hwrite) begin
            next_hrdata = addr_hit ? 32'(ctrl_view) : RDATA_NONE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hrdata <= RDATA_NONE;
        end else begin
            hrdata <= next_hrdata;
        end
    end

    // ----------------------------------------------------------------------
    // clock source switch
    // ----------------------------------------------------------------------
    clock_source_switch u_switch (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .slow_osc  (slow_osc),
        .fast_osc  (fast_osc),
        .want_fast (cpu_clock_select),
        .cpu_clock (cpu_clock),
        .on_fast   (cpu_on_fast)
    );

    // ----------------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------------
    property p_sel_write;
        @(posedge clk_sys) disable iff (rst)
        wr_pend && !sel_refused |=> cpu_clock_select == $past(hwdata[SEL_BIT]);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("clock select not stored");

    property p_fast_needs_sel;
        @(posedge clk_sys) disable iff (rst)
        $rose(cpu_on_fast) |-> $past(cpu_clock_select);
    endproperty
    a_fast_needs_sel: assert property (p_fast_needs_sel) else $error("fast clock unrequested");

    property p_osc_write;
        @(posedge clk_sys) disable iff (rst)
        wr_pend |=> fast_osc_run == $past(hwdata[OSC_BIT]);
    endproperty
    a_osc_write: assert property (p_osc_write) else $error("oscillator enable wrong");

    property p_vdc_write;
        @(posedge clk_sys) disable iff (rst)
        wr_pend |=> core_supply_level == (slow_osc_is_rc || $past(hwdata[VDC_BIT]));
    endproperty
    a_vdc_write: assert property (p_vdc_write) else $error("supply level wrong");

    property p_rc_fixed;
        @(posedge clk_sys) disable iff (rst)
        slow_osc_is_rc && wr_pend |=> core_supply_level;
    endproperty
    a_rc_fixed: assert property (p_rc_fixed) else $error("supply left high level");

    property p_reset_state;
        @(posedge clk_sys)
        rst |=> !cpu_clock_select && !fast_osc_run && !core_voltage_select && !cpu_on_fast;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

    property p_unused_bit;
        @(posedge clk_sys) disable iff (rst)
        rd_pend |-> !hrdata[RSV_BIT];
    endproperty
    a_unused_bit: assert property (p_unused_bit) else $error("unused bit read as one");

    property p_refused;
        @(posedge clk_sys) disable iff (rst)
        wr_pend && !slow_osc_is_rc && !core_voltage_select && !fast_osc_enable
            |=> !cpu_clock_select ##1 !cpu_on_fast;
    endproperty
    a_refused: assert property (p_refused) else $error("refused select took effect");

    property p_stay_slow;
        @(posedge clk_sys) disable iff (rst)
        !cpu_clock_select && !cpu_on_fast |=> !cpu_on_fast;
    endproperty
    a_stay_slow: assert property (p_stay_slow) else $error("left slow clock unasked");

    property p_zero_wait;
        @(posedge clk_sys) disable iff (rst)
        hreadyout && (hresp == HRESP_OKAY);
    endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("bus not ready or error");

    property p_upper_zero;
        @(posedge clk_sys) disable iff (rst)
        rd_pend |-> (hrdata[31:CTRL_W] == '0);
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");

    property p_sel_hold;
        @(posedge clk_sys) disable iff (rst)
        !wr_pend |=> $stable(cpu_clock_select);
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("clock select changed");

    property p_osc_hold;
        @(posedge clk_sys) disable iff (rst)
        !wr_pend |=> $stable(fast_osc_run);
    endproperty
    a_osc_hold: assert property (p_osc_hold) else $error("oscillator enable changed");

    property p_vdc_hold;
        @(posedge clk_sys) disable iff (rst)
        !wr_pend |=> $stable(core_voltage_select);
    endproperty
    a_vdc_hold: assert property (p_vdc_hold) else $error("voltage select changed");

    property p_supply_follow;
        @(posedge clk_sys) disable iff (rst)
        core_supply_level == (slow_osc_is_rc || core_voltage_select);
    endproperty
    a_supply_follow: assert property (p_supply_follow) else $error("supply mismatch");

    property p_rc_high;
        @(posedge clk_sys) disable iff (rst)
        slow_osc_is_rc |-> core_supply_level;
    endproperty
    a_rc_high: assert property (p_rc_high) else $error("rc supply not high");

    property p_fast_follow;
        @(posedge clk_sys) disable iff (rst)
        cpu_on_fast && $past(cpu_on_fast) |-> cpu_clock == $past(fast_osc);
    endproperty
    a_fast_follow: assert property (p_fast_follow) else $error("fast clock not passed");

    property p_leave_fast;
        @(posedge clk_sys) disable iff (rst)
        $fell(cpu_on_fast) |-> !$past(cpu_clock_select);
    endproperty
    a_leave_fast: assert property (p_leave_fast) else $error("left fast clock unasked");

    property p_refuse_store;
        @(posedge clk_sys) disable iff (rst)
        wr_pend && sel_refused |=> !cpu_clock_select;
    endproperty
    a_refuse_store: assert property (p_refuse_store) else $error("refused select stored");

    property p_reset_read;
        @(posedge clk_sys)
        rst |=> hrdata == RDATA_NONE;
    endproperty
    a_reset_read: assert property (p_reset_read) else $error("read data not cleared");

    property p_hrdata_hold;
        @(posedge clk_sys) disable iff (rst)
        !(addr_take && !hwrite) |=> $stable(hrdata);
    endproperty
    a_hrdata_hold: assert property (p_hrdata_hold) else $error("read data moved");

    c_to_fast: cover property (@(posedge clk_sys) disable iff (rst) $rose(cpu_on_fast));
    c_to_slow: cover property (@(posedge clk_sys) disable iff (rst) $fell(cpu_on_fast));
    c_refuse:  cover property (@(posedge clk_sys) disable iff (rst)
        wr_pend && hwdata[SEL_BIT] && sel_refused);
    c_read:    cover property (@(posedge clk_sys) disable iff (rst) rd_pend && hrdata != 0);

endmodule

// file: verif/tb_cpu_clock_and_core_voltage_ctrl.sv
/*
 * Self-checking bench for the clock source and core voltage control block:
 * bus tasks, reset values, refusal table, clock switch round trip.
 * Assumes the design package is compiled first; a crystal build and an RC
 * build share the bus, and read data is taken from both.
 */
`timescale 1ns/1ps
module tb_cpu_clock_and_core_voltage_ctrl;
    import clock_ctrl_pkg::*;

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    logic        hsel    = 1'b0;
    logic        hwrite  = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [31:0] hwdata  = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic [2:0]  hsize   = 3'h2;
    logic        slow_osc = 1'b0;
    logic        fast_osc = 1'b0;
    logic        slow_d  = 1'b0;
    logic        fast_d  = 1'b0;
    logic [3:0]  osc_cnt = 4'h0;
    logic        hready, hresp, hresp_rc, cpu_clock, cpu_on_fast;
    logic        fast_osc_run, core_supply_level, supply_rc;
    logic [31:0] hrdata, hrdata_rc, q, qr;
    logic [3:0]  prior;
    int          n_mismatch = 0;
    int          n_tests    = 0;

    cpu_clock_and_core_voltage_ctrl #(.slow_osc_is_rc(1'b0)) uut (
        .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .slow_osc(slow_osc),
        .fast_osc(fast_osc), .cpu_clock(cpu_clock), .cpu_on_fast(cpu_on_fast),
        .fast_osc_run(fast_osc_run), .core_supply_level(core_supply_level));

    cpu_clock_and_core_voltage_ctrl #(.slow_osc_is_rc(1'b1)) uut_rc (
        .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(), .hresp(hresp_rc), .hrdata(hrdata_rc), .slow_osc(slow_osc),
        .fast_osc(fast_osc), .cpu_clock(), .cpu_on_fast(), .fast_osc_run(),
        .core_supply_level(supply_rc));

    // ------------------------------------------------------------------
    // clock and oscillators
    // ------------------------------------------------------------------
    always #2.5 clk_sys = ~clk_sys;

    // fast toggles each cycle, slow every eight; delayed copies for compare
    always @(posedge clk_sys) begin
        osc_cnt  <= osc_cnt + 4'h1;
        fast_osc <= osc_cnt[0];
        slow_osc <= osc_cnt[3];
        fast_d   <= fast_osc;
        slow_d   <= slow_osc;
    end

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hready !== 1'b1 && n < 64);
    endtask

    // entered just after a rising edge, returns at the edge ending the data phase
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        q  = hrdata;
        qr = hrdata_rc;
        check({30'h0, hresp_rc, hresp}, {30'h0, HRESP_OKAY, HRESP_OKAY});
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] ex, input logic [31:0] exr);
        bus(1'b0, a, 32'h0);
        check(q, ex);
        check(qr, exr);
    endtask

    task automatic wait_src(input logic exp);
        int n;
        n = 0;
        #1;
        while (cpu_on_fast !== exp && n < 200) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check(32'(cpu_on_fast), 32'(exp));
    endtask

    task automatic follow(input logic use_fast);
        int n;
        n = 0;
        // slow side joins only once slow_osc is low; the gap before shows 0
        if (!use_fast) begin
            @(posedge clk_sys);
            #1;
            while (slow_d !== 1'b0 && n < 40) begin
                @(posedge clk_sys);
                #1;
                n++;
            end
        end
        repeat (6) begin
            @(posedge clk_sys);
            #1;
            check(32'(cpu_clock), 32'(use_fast ? fast_d : slow_d));
        end
    endtask

    task automatic conclude;
        $display("mismatches %0d of %0d comparisons", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        conclude();
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        check({28'h0, fast_osc_run, core_supply_level, cpu_on_fast, supply_rc}, 32'h1);
        rd(CTRL_ADDR, 32'h0, 32'h0);
        $display("test reset values done");

        // select refused on crystal build, accepted on rc build; bit 1 dropped
        wr(CTRL_ADDR, 32'hffffffff);
        rd(CTRL_ADDR, 32'h5, 32'hd);
        check({30'h0, fast_osc_run, core_supply_level}, 32'h3);
        wr(CTRL_ADDR, 32'h5);
        wr(CTRL_ADDR, 32'h1);
        wr(CTRL_ADDR, 32'h0);
        wr(32'h0000ff04, 32'hf);
        rd(32'h0000ff04, 32'h0, 32'h0);
        rd(CTRL_ADDR, 32'h0, 32'h0);
        $display("test full write and unmapped done");

        // select from each prior setting of supply and oscillator enable
        for (int i = 0; i < 4; i++) begin
            prior = (i[0] ? 4'h1 : 4'h0) | (i[1] ? 4'h4 : 4'h0);
            wr(CTRL_ADDR, {28'h0, prior});
            wr(CTRL_ADDR, {28'h0, prior | 4'h8});
            rd(CTRL_ADDR, {28'h0, (i == 0) ? prior : (prior | 4'h8)}, {28'h0, prior | 4'h8});
            check({29'h0, fast_osc_run, core_supply_level, supply_rc}, 32'({prior[2], prior[0], 1'b1}));
            wr(CTRL_ADDR, {28'h0, prior});
            wr(CTRL_ADDR, {28'h0, prior & 4'h1});
            wr(CTRL_ADDR, 32'h0);
        end
        $display("test select refusal done");

        // software settling waits are not timed by hardware, so not spent here
        wr(CTRL_ADDR, 32'h1);
        wr(CTRL_ADDR, 32'h5);
        wr(CTRL_ADDR, 32'hd);
        rd(CTRL_ADDR, 32'hd, 32'hd);
        wait_src(1'b1);
        follow(1'b1);
        wr(CTRL_ADDR, 32'h5);
        wait_src(1'b0);
        follow(1'b0);
        wr(CTRL_ADDR, 32'h1);
        wr(CTRL_ADDR, 32'h0);
        #1;
        check({30'h0, fast_osc_run, core_supply_level}, 32'h0);
        rd(CTRL_ADDR, 32'h0, 32'h0);
        $display("test clock switch round trip done");
        conclude();
    end
endmodule
